// file: verilog/dsb_identity_bank.sv
// Drive status and identity parameter bank: versions, serial, monitor words,
// stop error code and power stage temperature, read over word-addressed access.
// Assumes inputs synchronous to clk_sys; one request per cycle; answer one cycle later.
// Function
// - Comm module firmware version readable as read-only 16-bit point-free decimal.
// - Device firmware version readable as read-only 16-bit point-free decimal.
// - Read-write 32-bit serial number, full unsigned range; reset loads SERIAL_INIT.
// - Serial number changes only while the power stage is disabled.
// - Read-only 32-bit present monitoring word, same layout as saved word.
// - Read-only 32-bit saved monitoring word, one means activated.
// - Bits 0-4: general, hw limit, out of range, quick stop, safe torque off zero.
// - Bits 6,7,8,12: RS485, CAN, Ethernet, Profibus.
// - Bit 9 reference frequency too high, bit 10 operating mode.
// - Bits 14,15,16: DC undervoltage, DC overvoltage, mains phase.
// - Bits 17-21: motor connection, overcurrent, encoder, 24V low, overtemperature.
// - Bits 22,23,24: position deviation, max velocity, safe torque off inputs differ.
// - Bits 29,30,31: nonvolatile memory, booting, system fault.
// - Bits 5, 11, 13, 25 to 28 are reserved and read zero.
// - Read-only 16-bit code of latest stopping error, reset zero.
// - Power stage temperature as read-only signed 16-bit degrees Celsius.
`timescale 1ns/100ps
`default_nettype none
module dsb_identity_bank #(
  parameter logic [15:0] COMM_FW_VERSION = dsb_pkg::DSB_FW_VERSION_DEF,
  parameter logic [15:0] DEV_FW_VERSION = dsb_pkg::DSB_FW_VERSION_DEF,
  parameter logic [31:0] SERIAL_INIT = dsb_pkg::DSB_SERIAL_DEF,
  parameter int MON_W = dsb_pkg::DSB_MW
) (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [dsb_pkg::DSB_AW-1:0] par_addr, // Parameter word address
  input wire logic par_rd, // Read request
  input wire logic par_wr, // Write request
  input wire logic [dsb_pkg::DSB_DW-1:0] par_wdata, // Write data
  output logic [dsb_pkg::DSB_DW-1:0] par_rdata, // Read data
  output logic par_rvalid, // Read answer pulse
  output logic par_wack, // Write accepted pulse
  output logic par_err, // Request refused pulse
  input wire logic power_stage_enabled, // Power stage enabled level
  input wire logic [dsb_pkg::DSB_MW-1:0] monitor_present_in, // Raw monitoring signals
  input wire logic monitor_clear, // Clear saved monitoring word
  input wire logic stop_event, // Stopping error detected pulse
  input wire logic [dsb_pkg::DSB_DW-1:0] stop_code_in, // Code of that error
  input wire logic signed [dsb_pkg::DSB_DW-1:0] power_stage_temp_in // Temperature, deg C
);
  import dsb_pkg::*;

  logic [DSB_MW-1:0] monitor_present_ff;
  logic [DSB_MW-1:0] monitor_saved_ff;
  logic [DSB_MW-1:0] unit_serial_ff;
  logic [DSB_DW-1:0] stop_error_code_ff;
  logic signed [DSB_DW-1:0] power_stage_temp_ff;
  logic [DSB_DW-1:0] nxt_rdata;
  logic nxt_rd_hit;
  logic nxt_wr_hit;
  logic both_req;
  dsb_sel_e rd_sel;

  initial begin
    if (MON_W != DSB_MW) begin
      $error("dsb_identity_bank: MON_W must equal 32");
    end
  end

  function automatic dsb_sel_e dsb_decode(input logic [DSB_AW-1:0] a);
    dsb_sel_e s;
    s = DSB_SEL_NONE;
    case (a)
      DSB_ADDR_COMM_FW: s = DSB_SEL_COMM_FW;
      DSB_ADDR_DEV_FW: s = DSB_SEL_DEV_FW;
      DSB_ADDR_SERIAL: s = DSB_SEL_SER_HI;
      DSB_ADDR_SERIAL + DSB_ADDR_LO_OFS: s = DSB_SEL_SER_LO;
      DSB_ADDR_STOP: s = DSB_SEL_STOP;
      DSB_ADDR_PRESENT: s = DSB_SEL_PRES_HI;
      DSB_ADDR_PRESENT + DSB_ADDR_LO_OFS: s = DSB_SEL_PRES_LO;
      DSB_ADDR_SAVED: s = DSB_SEL_SAVED_HI;
      DSB_ADDR_SAVED + DSB_ADDR_LO_OFS: s = DSB_SEL_SAVED_LO;
      DSB_ADDR_TEMP: s = DSB_SEL_TEMP;
      default: s = DSB_SEL_NONE;
    endcase
    return s;
  endfunction : dsb_decode

  // Monitoring snapshot; unassigned positions forced to zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      monitor_present_ff <= DSB_MON_RST;
    end else begin
      monitor_present_ff <= monitor_present_in & DSB_MON_USED_MASK;
    end
  end

  dsb_sticky_word #(
    .W(DSB_MW)
  ) u_saved (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_bits(monitor_present_ff),
    .clr(monitor_clear),
    .q_ff(monitor_saved_ff)
  );

  assign both_req = par_rd && par_wr;
  assign rd_sel = dsb_decode(par_addr);

  // Serial number: only the two serial words are writable, power stage off only
  assign nxt_wr_hit = par_wr && !both_req && !power_stage_enabled &&
                      (rd_sel == DSB_SEL_SER_HI || rd_sel == DSB_SEL_SER_LO);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      unit_serial_ff <= SERIAL_INIT;
    end else if (nxt_wr_hit) begin
      if (rd_sel == DSB_SEL_SER_HI) begin
        unit_serial_ff[31:16] <= par_wdata;
      end else begin
        unit_serial_ff[15:0] <= par_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stop_error_code_ff <= DSB_STOP_CODE_RST;
    end else if (stop_event) begin
      stop_error_code_ff <= stop_code_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      power_stage_temp_ff <= DSB_TEMP_RST;
    end else begin
      power_stage_temp_ff <= power_stage_temp_in;
    end
  end

  // Read mux; 32-bit values give the high word at the base address
  always_comb begin
    nxt_rdata = DSB_RDATA_RST;
    nxt_rd_hit = 1'b1;
    case (rd_sel)
      DSB_SEL_COMM_FW: nxt_rdata = COMM_FW_VERSION;
      DSB_SEL_DEV_FW: nxt_rdata = DEV_FW_VERSION;
      DSB_SEL_SER_HI: nxt_rdata = unit_serial_ff[31:16];
      DSB_SEL_SER_LO: nxt_rdata = unit_serial_ff[15:0];
      DSB_SEL_STOP: nxt_rdata = stop_error_code_ff;
      DSB_SEL_PRES_HI: nxt_rdata = monitor_present_ff[31:16];
      DSB_SEL_PRES_LO: nxt_rdata = monitor_present_ff[15:0];
      DSB_SEL_SAVED_HI: nxt_rdata = monitor_saved_ff[31:16];
      DSB_SEL_SAVED_LO: nxt_rdata = monitor_saved_ff[15:0];
      DSB_SEL_TEMP: nxt_rdata = power_stage_temp_ff;
      default: nxt_rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      par_rdata <= DSB_RDATA_RST;
      par_rvalid <= 1'b0;
    end else begin
      par_rvalid <= par_rd && !both_req && nxt_rd_hit;
      if (par_rd && !both_req && nxt_rd_hit) begin
        par_rdata <= nxt_rdata;
      end
    end
  end

  // Refusals: unmapped read, any refused write, read and write together
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      par_wack <= 1'b0;
      par_err <= 1'b0;
    end else begin
      par_wack <= nxt_wr_hit;
      par_err <= both_req || (par_rd && !nxt_rd_hit) || (par_wr && !nxt_wr_hit);
    end
  end

  a_comm_fw_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_COMM_FW |=> par_rvalid && par_rdata == COMM_FW_VERSION)
    else $error("comm firmware version read wrong");

  a_dev_fw_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_DEV_FW |=> par_rvalid && par_rdata == DEV_FW_VERSION)
    else $error("device firmware version read wrong");

  a_serial_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
    power_stage_enabled |=> $stable(unit_serial_ff) && !par_wack)
    else $error("serial changed while power stage enabled");

  a_serial_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_wr && !par_rd && !power_stage_enabled && par_addr == DSB_ADDR_SERIAL
    |=> par_wack && unit_serial_ff[31:16] == $past(par_wdata))
    else $error("serial high word write not taken");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (monitor_present_ff & ~DSB_MON_USED_MASK) == DSB_MON_RST)
    else $error("reserved monitoring bit set");

  a_present_track: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> monitor_present_ff == ($past(monitor_present_in) & DSB_MON_USED_MASK))
    else $error("present monitoring word stale");

  a_saved_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> (monitor_saved_ff & $past(monitor_present_ff)) == $past(monitor_present_ff))
    else $error("saved monitoring bit not set");

  a_saved_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !monitor_clear |=> (monitor_saved_ff & $past(monitor_saved_ff)) == $past(monitor_saved_ff))
    else $error("saved monitoring bit lost without clear");

  a_stop_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stop_event ##1 (!stop_event)[*2] |-> stop_error_code_ff == $past(stop_code_in, 2))
    else $error("stop error code not captured");

  a_temp_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_TEMP |=> par_rdata == $past(power_stage_temp_ff))
    else $error("temperature read wrong");

  a_unmapped_err: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && dsb_decode(par_addr) == DSB_SEL_NONE |=> par_err && !par_rvalid)
    else $error("unmapped read not refused");

  a_serial_lo_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_wr && !par_rd && !power_stage_enabled && par_addr == DSB_ADDR_SERIAL + DSB_ADDR_LO_OFS
    |=> par_wack && unit_serial_ff[15:0] == $past(par_wdata))
    else $error("serial low word write not taken");

  a_serial_refused: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_wr && !par_rd && power_stage_enabled |=> par_err && !par_wack)
    else $error("serial write not refused while power stage enabled");

  a_wack_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_wack |-> $past(par_wr) && !$past(par_rd) && !$past(power_stage_enabled))
    else $error("write acknowledged without a permitted request");

  a_serial_hi_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_SERIAL
    |=> par_rvalid && par_rdata == $past(unit_serial_ff[31:16]))
    else $error("serial high word read wrong");

  a_serial_lo_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_SERIAL + DSB_ADDR_LO_OFS
    |=> par_rvalid && par_rdata == $past(unit_serial_ff[15:0]))
    else $error("serial low word read wrong");

  a_stop_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_STOP
    |=> par_rvalid && par_rdata == $past(stop_error_code_ff))
    else $error("stop error code read wrong");

  a_stop_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !stop_event |=> $stable(stop_error_code_ff))
    else $error("stop error code changed without an event");

  a_temp_track: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> power_stage_temp_ff == $past(power_stage_temp_in))
    else $error("temperature register stale");

  a_present_hi_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_PRESENT
    |=> par_rvalid && par_rdata == $past(monitor_present_ff[31:16]))
    else $error("present monitoring high word read wrong");

  a_present_lo_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_PRESENT + DSB_ADDR_LO_OFS
    |=> par_rvalid && par_rdata == $past(monitor_present_ff[15:0]))
    else $error("present monitoring low word read wrong");

  a_saved_hi_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_SAVED
    |=> par_rvalid && par_rdata == $past(monitor_saved_ff[31:16]))
    else $error("saved monitoring high word read wrong");

  a_saved_lo_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && !par_wr && par_addr == DSB_ADDR_SAVED + DSB_ADDR_LO_OFS
    |=> par_rvalid && par_rdata == $past(monitor_saved_ff[15:0]))
    else $error("saved monitoring low word read wrong");

  a_saved_cleared: assert property (@(posedge clk_sys) disable iff (!rst_b)
    monitor_clear |=> monitor_saved_ff == $past(monitor_present_ff))
    else $error("saved monitoring word not cleared");

  a_saved_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (monitor_saved_ff & ~DSB_MON_USED_MASK) == DSB_MON_RST)
    else $error("reserved saved monitoring bit set");

  a_both_refused: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && par_wr |=> par_err && !par_rvalid && !par_wack)
    else $error("read and write together not refused");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !par_rvalid |-> $stable(par_rdata))
    else $error("read data changed without an answer");

  a_rvalid_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_rvalid |-> $past(par_rd) && !$past(par_wr))
    else $error("read answer without a read request");

  a_pulse_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    par_err |-> !par_rvalid && !par_wack)
    else $error("refusal together with an answer");

  c_serial_taken: cover property (@(posedge clk_sys) disable iff (!rst_b) par_wack);
  c_serial_refused: cover property (@(posedge clk_sys) disable iff (!rst_b)
    par_wr && power_stage_enabled ##1 par_err);
  c_saved_clear: cover property (@(posedge clk_sys) disable iff (!rst_b)
    monitor_saved_ff != DSB_MON_RST && monitor_clear ##1 monitor_saved_ff == DSB_MON_RST);
  c_saved_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && par_addr == DSB_ADDR_SAVED ##1 par_rvalid);
  c_both_refused: cover property (@(posedge clk_sys) disable iff (!rst_b)
    par_rd && par_wr ##1 par_err);

endmodule : dsb_identity_bank
`default_nettype wire

// file: verilog/dsb_pkg.sv
// Constants for the drive status and identity parameter bank.
// Assumes word-addressed 16-bit parameter access; 32-bit values occupy two addresses.
`default_nettype none
package dsb_pkg;

  localparam int DSB_AW = 16;
  localparam int DSB_DW = 16;
  localparam int DSB_MW = 32;

  // Parameter addresses (16-bit word addresses); 32-bit values: high word first
  localparam logic [15:0] DSB_ADDR_DEV_FW = 16'h0104;
  localparam logic [15:0] DSB_ADDR_SERIAL = 16'h012E;
  localparam logic [15:0] DSB_ADDR_COMM_FW = 16'h1A16;
  localparam logic [15:0] DSB_ADDR_STOP = 16'h1C0A;
  localparam logic [15:0] DSB_ADDR_PRESENT = 16'h1C0E;
  localparam logic [15:0] DSB_ADDR_SAVED = 16'h1C10;
  localparam logic [15:0] DSB_ADDR_TEMP = 16'h1C20;
  localparam logic [15:0] DSB_ADDR_LO_OFS = 16'h0001;

  // Point-free decimal firmware version default, serial number default and reset values
  localparam logic [15:0] DSB_FW_VERSION_DEF = 16'h1069;
  localparam logic [31:0] DSB_SERIAL_DEF = 32'h0000_0000;
  localparam logic [15:0] DSB_STOP_CODE_RST = 16'h0000;
  localparam logic [15:0] DSB_TEMP_RST = 16'h0000;
  localparam logic [31:0] DSB_MON_RST = 32'h0000_0000;
  localparam logic [15:0] DSB_RDATA_RST = 16'h0000;

  // Monitoring bit positions
  localparam int MON_GENERAL = 0;
  localparam int MON_HW_LIMIT = 1;
  localparam int MON_OUT_OF_RANGE = 2;
  localparam int MON_QUICK_STOP = 3;
  localparam int MON_SAFE_TORQUE_OFF_LOW = 4;
  localparam int MON_RS485 = 6;
  localparam int MON_CAN = 7;
  localparam int MON_ETHERNET = 8;
  localparam int MON_REF_FREQ = 9;
  localparam int MON_OP_MODE = 10;
  localparam int MON_PROFIBUS = 12;
  localparam int MON_DC_UNDERVOLT = 14;
  localparam int MON_DC_OVERVOLT = 15;
  localparam int MON_MAINS_PHASE = 16;
  localparam int MON_MOTOR_CONN = 17;
  localparam int MON_MOTOR_OVERCUR = 18;
  localparam int MON_MOTOR_ENCODER = 19;
  localparam int MON_24V_UNDERVOLT = 20;
  localparam int MON_OVERTEMP = 21;
  localparam int MON_POS_DEVIATION = 22;
  localparam int MON_MAX_VELOCITY = 23;
  localparam int MON_SAFE_TORQUE_OFF_DIFF = 24;
  localparam int MON_NVM_ERROR = 29;
  localparam int MON_BOOTING = 30;
  localparam int MON_SYSTEM = 31;

  localparam logic [31:0] DSB_MON_USED_MASK =
    (32'h1 << MON_GENERAL) | (32'h1 << MON_HW_LIMIT) | (32'h1 << MON_OUT_OF_RANGE) |
    (32'h1 << MON_QUICK_STOP) | (32'h1 << MON_SAFE_TORQUE_OFF_LOW) |
    (32'h1 << MON_RS485) |
    (32'h1 << MON_CAN) | (32'h1 << MON_ETHERNET) | (32'h1 << MON_REF_FREQ) |
    (32'h1 << MON_OP_MODE) | (32'h1 << MON_PROFIBUS) | (32'h1 << MON_DC_UNDERVOLT) |
    (32'h1 << MON_DC_OVERVOLT) | (32'h1 << MON_MAINS_PHASE) | (32'h1 << MON_MOTOR_CONN) |
    (32'h1 << MON_MOTOR_OVERCUR) | (32'h1 << MON_MOTOR_ENCODER) |
    (32'h1 << MON_24V_UNDERVOLT) | (32'h1 << MON_OVERTEMP) | (32'h1 << MON_POS_DEVIATION) |
    (32'h1 << MON_MAX_VELOCITY) | (32'h1 << MON_SAFE_TORQUE_OFF_DIFF) |
    (32'h1 << MON_NVM_ERROR) |
    (32'h1 << MON_BOOTING) | (32'h1 << MON_SYSTEM);

  typedef enum logic [3:0] {
    DSB_SEL_NONE,
    DSB_SEL_COMM_FW,
    DSB_SEL_DEV_FW,
    DSB_SEL_SER_HI,
    DSB_SEL_SER_LO,
    DSB_SEL_STOP,
    DSB_SEL_PRES_HI,
    DSB_SEL_PRES_LO,
    DSB_SEL_SAVED_HI,
    DSB_SEL_SAVED_LO,
    DSB_SEL_TEMP
  } dsb_sel_e;

endpackage : dsb_pkg
`default_nettype wire

// file: verilog/dsb_sticky_word.sv
// Sticky word: each bit sets while its input is one and holds until cleared.
// Assumes a single clock and synchronous active-low reset; set wins over clear.
`timescale 1ns/100ps
`default_nettype none
module dsb_sticky_word #(
  parameter int W = 32
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [W-1:0] set_bits, // Bits to set this cycle
  input wire logic clr, // Clear all bits
  output logic [W-1:0] q_ff // Saved word
);
  import dsb_pkg::*;

  initial begin
    if (W < 1 || W > DSB_MW) begin
      $error("dsb_sticky_word: W out of range");
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q_ff <= DSB_MON_RST[W-1:0];
    end else begin
      q_ff <= (q_ff & ~{W{clr}}) | set_bits;
    end
  end

endmodule : dsb_sticky_word
`default_nettype wire

// file: test/dsb_master_model.sv
// Fieldbus master model: issues single-word parameter reads and writes.
// Assumes the bank answers on the edge that takes a request, before the next falling edge.
`timescale 1ns/100ps
`default_nettype none
module dsb_master_model (
  input wire logic clk_sys, // System clock
  output logic [dsb_pkg::DSB_AW-1:0] par_addr, // Word address
  output logic par_rd, // Read request
  output logic par_wr, // Write request
  output logic [dsb_pkg::DSB_DW-1:0] par_wdata, // Write data
  input wire logic [dsb_pkg::DSB_DW-1:0] par_rdata, // Read data
  input wire logic par_rvalid, // Read answer
  input wire logic par_wack, // Write accepted
  input wire logic par_err // Request refused
);
  import dsb_pkg::*;
  initial begin
    par_addr = 16'h0000;
    par_rd = 1'b0;
    par_wr = 1'b0;
    par_wdata = 16'h0000;
  end
  // One request; on release rd/wr drop and address and data are inverted so stale values never look valid
  task req(input logic [15:0] a, input logic w, input logic [15:0] d,
           output logic [15:0] q, output logic [1:0] s);
    @(posedge clk_sys);
    par_addr <= a;
    par_rd <= ~w;
    par_wr <= w;
    par_wdata <= d;
    @(posedge clk_sys);
    par_rd <= 1'b0;
    par_wr <= 1'b0;
    par_addr <= ~a;
    par_wdata <= ~d;
    @(negedge clk_sys);
    q = par_rdata;
    s = {(w ? par_wack : par_rvalid), par_err};
    // Return on a rising edge so the caller's stimulus lands there
    @(posedge clk_sys);
  endtask : req
  // Read and write raised together; the bank must refuse the pair
  task req_both(input logic [15:0] a, input logic [15:0] d, output logic [1:0] s);
    @(posedge clk_sys);
    par_addr <= a;
    par_rd <= 1'b1;
    par_wr <= 1'b1;
    par_wdata <= d;
    @(posedge clk_sys);
    par_rd <= 1'b0;
    par_wr <= 1'b0;
    par_addr <= ~a;
    par_wdata <= ~d;
    @(negedge clk_sys);
    s = {(par_rvalid | par_wack), par_err};
    @(posedge clk_sys);
  endtask : req_both
endmodule : dsb_master_model
`default_nettype wire

// file: test/test_drive_status_identity_bank.sv
// Testbench for the parameter bank, driven through the master model.
// Assumes answers on the edge that takes a request; stimulus at rising edges.
`timescale 1ns/100ps
`default_nettype none
module test_drive_status_identity_bank;
  import dsb_pkg::*;
  // Bits left after removing the reserved positions 5, 11, 13, 25..28
  localparam logic [31:0] USED = 32'hE1FF_D7DF;
  logic clk_sys, rst_b, par_rd, par_wr, par_rvalid, par_wack, par_err;
  logic [15:0] par_addr, par_wdata, par_rdata, stop_code_in, q;
  logic power_stage_enabled, monitor_clear, stop_event;
  logic [31:0] monitor_present_in, e;
  logic signed [15:0] power_stage_temp_in;
  logic [1:0] s;
  int err_total, tests_run, cyc, i;

  dsb_identity_bank #(.COMM_FW_VERSION(16'd4201), .DEV_FW_VERSION(16'd8401),
    .SERIAL_INIT(32'hFFFF_FFFF), .MON_W(32)) dsb_identity_bank_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .par_addr(par_addr), .par_rd(par_rd),
    .par_wr(par_wr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .par_wack(par_wack), .par_err(par_err),
    .power_stage_enabled(power_stage_enabled), .monitor_present_in(monitor_present_in),
    .monitor_clear(monitor_clear), .stop_event(stop_event), .stop_code_in(stop_code_in),
    .power_stage_temp_in(power_stage_temp_in));
  dsb_master_model dsb_master_model_inst (.clk_sys(clk_sys), .par_addr(par_addr),
    .par_rd(par_rd), .par_wr(par_wr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .par_wack(par_wack), .par_err(par_err));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task rd_chk(input logic [15:0] a, input logic [15:0] x);
    dsb_master_model_inst.req(a, 1'b0, 16'h0000, q, s);
    chk({30'h0, s}, 32'h2);
    chk({16'h0, q}, {16'h0, x});
  endtask : rd_chk

  task rd32_chk(input logic [15:0] a, input logic [31:0] x);
    rd_chk(a, x[31:16]);
    rd_chk(a + DSB_ADDR_LO_OFS, x[15:0]);
  endtask : rd32_chk

  task req_st(input logic [15:0] a, input logic w, input logic [15:0] d, input logic [1:0] x);
    dsb_master_model_inst.req(a, w, d, q, s);
    chk({30'h0, s}, {30'h0, x});
  endtask : req_st

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    power_stage_enabled = 1'b0;
    monitor_present_in = 32'h0000_0000;
    monitor_clear = 1'b0;
    stop_event = 1'b0;
    stop_code_in = 16'h0000;
    power_stage_temp_in = 16'sh0000;
    tick(6);
    rst_b <= 1'b1;
    rd_chk(DSB_ADDR_COMM_FW, 16'd4201);
    rd_chk(DSB_ADDR_DEV_FW, 16'd8401);
    rd32_chk(DSB_ADDR_SERIAL, 32'hFFFF_FFFF);
    rd_chk(DSB_ADDR_STOP, 16'h0000);
    @(posedge clk_sys);
    power_stage_enabled <= 1'b1;
    req_st(DSB_ADDR_SERIAL, 1'b1, 16'h1234, 2'b01);
    rd32_chk(DSB_ADDR_SERIAL, 32'hFFFF_FFFF);
    power_stage_enabled <= 1'b0;
    req_st(DSB_ADDR_SERIAL, 1'b1, 16'h0000, 2'b10);
    req_st(DSB_ADDR_SERIAL + DSB_ADDR_LO_OFS, 1'b1, 16'h0001, 2'b10);
    rd32_chk(DSB_ADDR_SERIAL, 32'h0000_0001);
    dsb_master_model_inst.req_both(DSB_ADDR_SERIAL, 16'hBEEF, s);
    chk({30'h0, s}, 32'h1);
    rd32_chk(DSB_ADDR_SERIAL, 32'h0000_0001);
    req_st(DSB_ADDR_COMM_FW, 1'b1, 16'h0000, 2'b01);
    rd_chk(DSB_ADDR_COMM_FW, 16'd4201);
    req_st(DSB_ADDR_TEMP, 1'b1, 16'h0007, 2'b01);
    req_st(16'h0200, 1'b0, 16'h0000, 2'b01);
    power_stage_temp_in <= -16'sd5;
    tick(2);
    rd_chk(DSB_ADDR_TEMP, 16'hFFFB);
    stop_code_in <= 16'h0ABC;
    stop_event <= 1'b1;
    @(posedge clk_sys);
    stop_event <= 1'b0;
    stop_code_in <= 16'h1111;
    rd_chk(DSB_ADDR_STOP, 16'h0ABC);
    // Walk every bit through present, saved, hold and clear
    for (i = 0; i < 32; i++) begin
      e = (32'h1 << i) & USED;
      monitor_present_in <= 32'h1 << i;
      tick(3);
      rd32_chk(DSB_ADDR_PRESENT, e);
      rd32_chk(DSB_ADDR_SAVED, e);
      monitor_present_in <= 32'h0000_0000;
      tick(3);
      rd32_chk(DSB_ADDR_PRESENT, 32'h0000_0000);
      rd32_chk(DSB_ADDR_SAVED, e);
      monitor_clear <= 1'b1;
      tick(2);
      monitor_clear <= 1'b0;
      rd32_chk(DSB_ADDR_SAVED, 32'h0000_0000);
    end
    // Set and clear together: set wins
    monitor_present_in <= 32'hFFFF_FFFF;
    monitor_clear <= 1'b1;
    tick(3);
    rd32_chk(DSB_ADDR_SAVED, USED);
    monitor_clear <= 1'b0;
    monitor_present_in <= 32'h0000_0000;
    tick(2);
    complete_run();
  end
endmodule : test_drive_status_identity_bank
`default_nettype wire
